// >>> src/timer_and_interrupt_unit.sv
// Five timers with the interrupt flag and enable registers.
`timescale 1ns/100ps
module timer_and_interrupt_unit
   import timer_unit_pkg::*;
#(
   parameter int FIFO_DEPTH = 512,
   parameter int FIFO_AW = 10
)
(
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_rst,
   // Register port.
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // Event sources.
   input wire logic i_tx_eof_start,
   input wire logic i_rx_end,
   input wire logic i_cmd_busy,
   input wire logic [FIFO_AW-1:0] i_fifo_count,
   input wire logic [7:0] i_rx_err,
   input wire logic i_rx_sof,
   input wire logic i_low_power_card_sensing_mode,
   input wire logic i_card_found,
   input wire logic i_card_check_done,
   input wire logic [3:0] i_stop_event,
   // Low-power oscillator pin.
   input wire logic i_lpo_clk,
   // Host request and power.
   output logic o_int_req,
   output logic o_standby,
   output logic o_wake
);
   logic [7:0] flags_a;
   logic [7:0] flags_b;
   logic [7:0] en_a;
   logic [7:0] en_b;
   logic [7:0] water;
   logic pin_en;
   logic [7:0] tctrl [NUM_TIMERS];
   logic [15:0] treload [NUM_TIMERS];
   logic [15:0] cnt_arr [NUM_TIMERS];
   logic [NUM_TIMERS-1:0] run_vec;
   logic [NUM_TIMERS-1:0] uf_vec;
   logic [13:0] acc;
   logic carrier_tick;
   logic [5:0] slow_cnt;
   logic slow_tick;
   logic lpo_s1;
   logic lpo_s2;
   logic lpo_s3;
   logic lpo_tick;
   logic cmd_busy_d;
   logic hi_d;
   logic lo_d;
   logic [7:0] err_d;
   logic hi_now;
   logic lo_now;
   logic [7:0] hw_a;
   logic [7:0] hw_b;
   logic [7:0] next_flags_a;
   logic [7:0] next_flags_b;
   logic wr_fa;
   logic wr_fb;
   logic wr_gc;
   logic any_pending;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Bit 7 of the write picks set or clear; hardware sets always win.
   function automatic logic [7:0] apply_write(
      input logic [7:0] cur,
      input logic [7:0] hw,
      input logic wr,
      input logic [7:0] wd
   );
      logic [7:0] val;
      val = cur;
      if (wr) begin
         if (wd[WR_SET_BIT]) begin
            val = cur | {1'b0, wd[6:0]};
         end else begin
            val = cur & ~{1'b0, wd[6:0]};
         end
      end
      return (val | hw) & 8'h7f;
   endfunction

   function automatic logic sel_tick(
      input clk_sel_type sel,
      input logic car,
      input logic slow,
      input logic uf0,
      input logic uf1
   );
      logic t;
      case (sel)
         CLK_CARRIER: t = car;
         CLK_SLOW: t = slow;
         CLK_UF0: t = uf0;
         default: t = uf1;
      endcase
      return t;
   endfunction

   function automatic logic is_tmr(input logic [7:0] a);
      return a >= ADDR_TMR_BASE && a < ADDR_TMR_END;
   endfunction

   function automatic logic [2:0] tmr_idx(input logic [7:0] a);
      logic [7:0] d;
      d = a - ADDR_TMR_BASE;
      return d[5:3];
   endfunction

   // ----------------------------------------
   // Tick sources
   // ----------------------------------------
   // A phase accumulator gives an exact long-run carrier rate from the
   // system clock; single ticks jitter by one system cycle.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         acc <= 14'h0000;
         carrier_tick <= 1'b0;
      end else if (acc + ACC_STEP >= ACC_MOD) begin
         acc <= acc + ACC_STEP - ACC_MOD;
         carrier_tick <= 1'b1;
      end else begin
         acc <= acc + ACC_STEP;
         carrier_tick <= 1'b0;
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         slow_cnt <= 6'h00;
         slow_tick <= 1'b0;
      end else begin
         slow_tick <= carrier_tick && slow_cnt == SLOW_DIV_LAST;
         if (carrier_tick) begin
            slow_cnt <= slow_cnt + 6'h01;
         end
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         lpo_s1 <= 1'b0;
         lpo_s2 <= 1'b0;
         lpo_s3 <= 1'b0;
      end else begin
         lpo_s1 <= i_lpo_clk;
         lpo_s2 <= lpo_s1;
         lpo_s3 <= lpo_s2;
      end
   end
   assign lpo_tick = lpo_s2 && !lpo_s3;

   // ----------------------------------------
   // Timer channels
   // ----------------------------------------
   assign wr_gc = i_wr && i_addr == ADDR_GCTRL;

   timer_ctrl_if tif [NUM_TIMERS] ();
   genvar g;
   for (g = 0; g < NUM_TIMERS; g++) begin : g_tim
      logic mode_start;
      assign mode_start = i_wr && is_tmr(i_addr) && tmr_idx(i_addr) == 3'(g)
         && i_addr[2:0] == SUB_CTRL && i_wdata[TC_START];
      if (g == WAKE_IDX) begin : g_wake
         assign tif[g].tick = lpo_tick;
         assign tif[g].start = mode_start;
         assign tif[g].stop = 1'b0;
      end else begin : g_gen
         assign tif[g].tick = sel_tick(clk_sel_type'(tctrl[g][1:0]),
            carrier_tick, slow_tick, uf_vec[0], uf_vec[1]);
         assign tif[g].start = mode_start
            || (wr_gc && i_wdata[GC_STROBE+g] && i_wdata[g]);
         assign tif[g].stop = (wr_gc && i_wdata[GC_STROBE+g] && !i_wdata[g])
            || (i_stop_event[g] && tctrl[g][TC_STOPEV]);
      end
      assign tif[g].auto_reload = tctrl[g][TC_AUTO];
      assign tif[g].reload = treload[g];
      assign cnt_arr[g] = tif[g].count;
      assign run_vec[g] = tif[g].running;
      assign uf_vec[g] = tif[g].underflow;
      timer_channel u_chan (
         .i_mclk(i_mclk),
         .i_rst(i_rst),
         .ctl(tif[g])
      );
   end

   // ----------------------------------------
   // Timer registers
   // ----------------------------------------
   // The start bit is a strobe and never stays stored.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         for (int n = 0; n < NUM_TIMERS; n++) begin
            tctrl[n] <= TCTRL_RST;
            treload[n] <= RELOAD_RST;
         end
      end else if (i_wr && is_tmr(i_addr)) begin
         for (int n = 0; n < NUM_TIMERS; n++) begin
            if (tmr_idx(i_addr) == 3'(n)) begin
               if (i_addr[2:0] == SUB_CTRL) begin
                  tctrl[n] <= i_wdata & ~(8'h01 << TC_START);
               end else if (i_addr[2:0] == SUB_RLD_HI) begin
                  treload[n][15:8] <= i_wdata;
               end else if (i_addr[2:0] == SUB_RLD_LO) begin
                  treload[n][7:0] <= i_wdata;
               end
            end
         end
      end
   end

   // ----------------------------------------
   // Event detection
   // ----------------------------------------
   assign hi_now = {1'b0, i_fifo_count} >= (FIFO_AW+1)'(FIFO_DEPTH) - {3'b000, water};
   assign lo_now = {1'b0, i_fifo_count} <= {3'b000, water};

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         cmd_busy_d <= 1'b0;
         hi_d <= 1'b0;
         lo_d <= 1'b0;
         err_d <= 8'h00;
      end else begin
         cmd_busy_d <= i_cmd_busy;
         hi_d <= hi_now;
         lo_d <= lo_now;
         err_d <= i_rx_err;
      end
   end

   always_comb begin
      hw_a = 8'h00;
      hw_a[FA_TX] = i_tx_eof_start;
      hw_a[FA_RX] = i_rx_end;
      hw_a[FA_IDLE] = cmd_busy_d && !i_cmd_busy;
      hw_a[FA_HIGH] = hi_now && !hi_d;
      hw_a[FA_LOW] = lo_now && !lo_d;
      hw_a[FA_ERR] = |(i_rx_err & ~err_d);
      hw_a[FA_SOF] = i_rx_sof;
   end

   // ----------------------------------------
   // Flags and request pin
   // ----------------------------------------
   assign wr_fa = i_wr && i_addr == ADDR_FLAGS_A;
   assign wr_fb = i_wr && i_addr == ADDR_FLAGS_B;

   always_comb begin
      hw_b = 8'h00;
      hw_b[NUM_TIMERS-1:0] = uf_vec;
      hw_b[FB_CARD] = i_card_found && i_low_power_card_sensing_mode;
      next_flags_a = apply_write(flags_a, hw_a, wr_fa, i_wdata);
      next_flags_b = apply_write(flags_b, hw_b, wr_fb, i_wdata);
      any_pending = |(next_flags_a & en_a) || |(next_flags_b[5:0] & en_b[5:0]);
      next_flags_b[FB_ANY] = next_flags_b[FB_ANY] || any_pending;
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         flags_a <= FLAGS_RST;
         flags_b <= FLAGS_RST;
      end else begin
         flags_a <= next_flags_a;
         flags_b <= next_flags_b;
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         en_a <= ENABLE_RST;
         en_b <= ENABLE_RST;
      end else begin
         en_a <= apply_write(en_a, 8'h00, i_wr && i_addr == ADDR_EN_A, i_wdata);
         en_b <= apply_write(en_b, 8'h00, i_wr && i_addr == ADDR_EN_B, i_wdata);
      end
   end

   // The pin follows the flag values being stored, so it changes together
   // with the flags while still coming straight from a flip-flop.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_int_req <= 1'b0;
      end else begin
         o_int_req <= (i_wr && i_addr == ADDR_POWER ? i_wdata[PW_PIN_EN] : pin_en)
            && (|(next_flags_a & en_a) || |(next_flags_b & en_b));
      end
   end

   // ----------------------------------------
   // Power and configuration
   // ----------------------------------------
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         pin_en <= POWER_RST[PW_PIN_EN];
         water <= WATER_RST;
      end else begin
         if (i_wr && i_addr == ADDR_POWER) begin
            pin_en <= i_wdata[PW_PIN_EN];
         end
         if (i_wr && i_addr == ADDR_WATER) begin
            water <= i_wdata;
         end
      end
   end

   // Wake-up wins over a sleep request arriving in the same cycle.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_standby <= POWER_RST[PW_STANDBY];
         o_wake <= 1'b0;
      end else begin
         o_wake <= uf_vec[WAKE_IDX];
         if (uf_vec[WAKE_IDX]) begin
            o_standby <= 1'b0;
         end else if (i_card_check_done && !i_card_found && tctrl[WAKE_IDX][TC_AUTOSLEEP]) begin
            o_standby <= 1'b1;
         end else if (i_wr && i_addr == ADDR_POWER && i_wdata[PW_STANDBY]) begin
            o_standby <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
      end else if (!i_rd) begin
         o_rdata <= 8'h00;
      end else if (i_addr == ADDR_FLAGS_A) begin
         o_rdata <= flags_a;
      end else if (i_addr == ADDR_FLAGS_B) begin
         o_rdata <= flags_b;
      end else if (i_addr == ADDR_EN_A) begin
         o_rdata <= en_a;
      end else if (i_addr == ADDR_EN_B) begin
         o_rdata <= en_b;
      end else if (i_addr == ADDR_STATUS) begin
         o_rdata <= {7'h00, flags_b[FB_ANY]};
      end else if (i_addr == ADDR_GCTRL) begin
         o_rdata <= {4'h0, run_vec[3:0]};
      end else if (i_addr == ADDR_POWER) begin
         o_rdata <= {6'h00, o_standby, pin_en};
      end else if (i_addr == ADDR_WATER) begin
         o_rdata <= water;
      end else if (is_tmr(i_addr)) begin
         if (i_addr[2:0] == SUB_CTRL) begin
            o_rdata <= tctrl[tmr_idx(i_addr)];
         end else if (i_addr[2:0] == SUB_RLD_HI) begin
            o_rdata <= treload[tmr_idx(i_addr)][15:8];
         end else if (i_addr[2:0] == SUB_RLD_LO) begin
            o_rdata <= treload[tmr_idx(i_addr)][7:0];
         end else if (i_addr[2:0] == SUB_CNT_HI) begin
            o_rdata <= cnt_arr[tmr_idx(i_addr)][15:8];
         end else if (i_addr[2:0] == SUB_CNT_LO) begin
            o_rdata <= cnt_arr[tmr_idx(i_addr)][7:0];
         end else begin
            o_rdata <= 8'h00;
         end
      end else begin
         o_rdata <= 8'h00;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   sequence gc_start0_s;
      i_wr && i_addr == ADDR_GCTRL && i_wdata[GC_STROBE] && i_wdata[0];
   endsequence
   sequence gc_stop0_s;
      i_wr && i_addr == ADDR_GCTRL && i_wdata[GC_STROBE] && !i_wdata[0];
   endsequence

   pin_follows_a: assert property (
      o_int_req == (pin_en && (|(flags_a & en_a) || |(flags_b & en_b))))
      else $error("request pin differs from enabled flags");
   flag_set_a: assert property (
      wr_fa && i_wdata[WR_SET_BIT] |=> (flags_a[6:0] & $past(i_wdata[6:0])) == $past(i_wdata[6:0]))
      else $error("set write did not set flag bits");
   flag_clear_a: assert property (
      wr_fa && !i_wdata[WR_SET_BIT] && hw_a == 8'h00 |=> (flags_a[6:0] & $past(i_wdata[6:0])) == 7'h00)
      else $error("clear write did not clear flag bits");
   tx_done_a: assert property (
      i_tx_eof_start |=> flags_a[FA_TX])
      else $error("transmit done flag not set");
   global_flag_a: assert property (
      |(flags_a & en_a) || |(flags_b[5:0] & en_b[5:0]) |-> flags_b[FB_ANY])
      else $error("global flag missing while enabled flag pending");
   timer_start_a: assert property (
      gc_start0_s |=> run_vec[0])
      else $error("timer 0 did not start");
   timer_stop_a: assert property (
      gc_stop0_s |=> !run_vec[0] ##1 !uf_vec[0])
      else $error("timer 0 did not stop quietly");
   timer_flag_a: assert property (
      uf_vec[1] |=> flags_b[1])
      else $error("timer 1 flag not set on underflow");
   fifo_high_a: assert property (
      hi_now && !hi_d |=> flags_a[FA_HIGH])
      else $error("fifo high flag not set");
   wake_pulse_a: assert property (
      uf_vec[WAKE_IDX] |=> o_wake && !o_standby)
      else $error("wake timer did not wake the system");
endmodule

// >>> inc/timer_unit_pkg.sv
// Constants and types of the timer and interrupt unit.
// Functional notes
// - Two 8-bit flag registers, each with an 8-bit enable register.
// - Write bit 7 selects set or clear of the written ones in bits 0-6.
// - Enabled events mark the status bit and, if activated, the request pin.
// - Transmit-done sets when transmitter moves from data to end-of-frame.
// - Receive-done sets when the received stream ends.
// - Command-idle sets when a running command returns to idle.
// - One water level gives top and bottom FIFO alerts; each sets a flag.
// - Error flag sets when any receive error bit becomes set.
// - Card-detect flag sets when a card is found in low-power sensing.
// - Receive-start flag sets on start-of-frame or subcarrier detection.
// - Global flag sets while any other enabled flag is set.
// - Five timers; first four pick carrier, slow clock or timer 0/1 underflow.
// - Each timer has a 16-bit count and a 16-bit reload, byte-wide access.
// - Wake timer on low-power oscillator wakes system, may return to standby.
// - Shared control register starts, stops and reports the four timers.
// - A running timer decrements once per selected tick.
// - At zero, the next tick raises the timer interrupt.
// - At underflow the timer stops or reloads, giving periodic interrupts.
// - The start bit of a timer's own control register starts it.
// - A stop event before underflow halts the timer with no interrupt.
// - Host can set and clear each timer flag directly.
package timer_unit_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int CARRIER_HZ = 13_560_000;
   localparam int ACC_GRAIN = 10_000;
   localparam logic [13:0] ACC_STEP = 14'(CARRIER_HZ / ACC_GRAIN);
   localparam logic [13:0] ACC_MOD = 14'(CLK_HZ / ACC_GRAIN);
   localparam logic [5:0] SLOW_DIV_LAST = 6'h3f;
   localparam int NUM_TIMERS = 5;
   localparam int WAKE_IDX = 4;
   localparam logic [7:0] ADDR_FLAGS_A = 8'h00;
   localparam logic [7:0] ADDR_FLAGS_B = 8'h01;
   localparam logic [7:0] ADDR_EN_A = 8'h02;
   localparam logic [7:0] ADDR_EN_B = 8'h03;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_GCTRL = 8'h05;
   localparam logic [7:0] ADDR_POWER = 8'h06;
   localparam logic [7:0] ADDR_WATER = 8'h07;
   localparam logic [7:0] ADDR_TMR_BASE = 8'h10;
   localparam logic [7:0] ADDR_TMR_END = 8'h38;
   localparam logic [2:0] SUB_CTRL = 3'h0;
   localparam logic [2:0] SUB_RLD_HI = 3'h1;
   localparam logic [2:0] SUB_RLD_LO = 3'h2;
   localparam logic [2:0] SUB_CNT_HI = 3'h3;
   localparam logic [2:0] SUB_CNT_LO = 3'h4;
   localparam int WR_SET_BIT = 7;
   localparam int FA_TX = 0;
   localparam int FA_RX = 1;
   localparam int FA_IDLE = 2;
   localparam int FA_HIGH = 3;
   localparam int FA_LOW = 4;
   localparam int FA_ERR = 5;
   localparam int FA_SOF = 6;
   localparam int FB_CARD = 5;
   localparam int FB_ANY = 6;
   localparam int TC_AUTO = 2;
   localparam int TC_START = 3;
   localparam int TC_STOPEV = 4;
   localparam int TC_AUTOSLEEP = 5;
   localparam int GC_STROBE = 4;
   localparam int PW_PIN_EN = 0;
   localparam int PW_STANDBY = 1;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [7:0] ENABLE_RST = 8'h00;
   localparam logic [7:0] TCTRL_RST = 8'h00;
   localparam logic [15:0] RELOAD_RST = 16'h0000;
   localparam logic [7:0] WATER_RST = 8'h08;
   localparam logic [7:0] POWER_RST = 8'h00;
   typedef enum logic [1:0] {
      CLK_CARRIER = 2'b00,
      CLK_SLOW = 2'b01,
      CLK_UF0 = 2'b10,
      CLK_UF1 = 2'b11
   } clk_sel_type;
   typedef enum logic {
      T_IDLE = 1'b0,
      T_RUN = 1'b1
   } timer_state_type;
endpackage

// >>> inc/timer_ctrl_if.sv
// Link between the register side and one timer channel.
`timescale 1ns/100ps
interface timer_ctrl_if;
   logic tick;
   logic start;
   logic stop;
   logic auto_reload;
   logic [15:0] reload;
   logic [15:0] count;
   logic running;
   logic underflow;
   modport unit (output tick, start, stop, auto_reload, reload, input count, running, underflow);
   modport chan (input tick, start, stop, auto_reload, reload, output count, running, underflow);
endinterface

// >>> src/timer_channel.sv
// One 16-bit down-counting timer channel.
`timescale 1ns/100ps
module timer_channel
   import timer_unit_pkg::*;
(
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_rst,
   // Control and state.
   timer_ctrl_if.chan ctl
);
   timer_state_type state;
   logic [15:0] count;
   logic underflow;

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   // The count is held after a stop so elapsed time can be read back.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         state <= T_IDLE;
         count <= RELOAD_RST;
      end else begin
         case (state)
            T_IDLE: begin
               if (ctl.start) begin
                  state <= T_RUN;
                  count <= ctl.reload;
               end
            end
            T_RUN: begin
               if (ctl.stop) begin
                  state <= T_IDLE;
               end else if (ctl.start) begin
                  count <= ctl.reload;
               end else if (ctl.tick) begin
                  if (count == 16'h0000) begin
                     if (ctl.auto_reload) begin
                        count <= ctl.reload;
                     end else begin
                        state <= T_IDLE;
                     end
                  end else begin
                     count <= count - 16'h0001;
                  end
               end
            end
            default: state <= T_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         underflow <= 1'b0;
      end else begin
         underflow <= state == T_RUN && !ctl.stop && !ctl.start && ctl.tick && count == 16'h0000;
      end
   end

   assign ctl.count = count;
   assign ctl.running = state == T_RUN;
   assign ctl.underflow = underflow;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   count_step_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      state == T_RUN && ctl.tick && !ctl.start && !ctl.stop && count != 16'h0000
      |=> count == $past(count) - 16'h0001)
      else $error("timer did not decrement on its tick");
   stop_quiet_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      ctl.stop |=> state == T_IDLE && !underflow)
      else $error("stopped timer ran on or raised underflow");
endmodule

// >>> bench/test_timer_and_interrupt_unit.sv
// Self-checking bench for the timer and interrupt unit.
`timescale 1ns/100ps
module test_timer_and_interrupt_unit;
   import timer_unit_pkg::*;
   logic i_mclk, i_rst, i_wr, i_rd, i_lpo_clk, o_int_req, o_standby, o_wake, low_power_card_sensing, cdone;
   logic [7:0] i_addr, i_wdata, o_rdata, ev, rv;
   logic [3:0] stop_ev;
   int err_count, checks_done, n;
   // Each bit of ev drives one event source; the FIFO level jumps to the top or bottom alert.
   timer_and_interrupt_unit dut_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_tx_eof_start(ev[0]), .i_rx_end(ev[1]),
      .i_cmd_busy(ev[2]), .i_fifo_count(ev[3] ? 10'h1f8 : (ev[4] ? 10'h008 : 10'h064)),
      .i_rx_err({7'h00, ev[5]}), .i_rx_sof(ev[6]), .i_low_power_card_sensing_mode(low_power_card_sensing), .i_card_found(ev[7]),
      .i_card_check_done(cdone), .i_stop_event(stop_ev), .i_lpo_clk(i_lpo_clk), .o_int_req(o_int_req),
      .o_standby(o_standby), .o_wake(o_wake));
   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   initial begin
      i_lpo_clk = 1'b0;
      forever #1517 i_lpo_clk = ~i_lpo_clk;
   end
   // ----------------------------------------
   // Bus cycles and comparison
   // ----------------------------------------
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 rv = o_rdata;
   endtask
   task rchk(input logic [7:0] a, input logic [15:0] e);
      rd(a);
      chk(16'(rv), e);
   endtask
   task pulse(input logic [7:0] m);
      @(posedge i_mclk);
      ev <= m;
      @(posedge i_mclk);
      ev <= 8'h00;
   endtask
   // Bounded so a silent timer shows up as a mismatch, not a hang.
   task wait_req();
      n = 0;
      #1;
      while (o_int_req !== 1'b1 && n < 300) begin
         @(posedge i_mclk);
         #1 n++;
      end
      chk(16'(o_int_req), 16'h0001);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task reset_values();
      rchk(ADDR_WATER, 16'h0008);
      rchk(ADDR_FLAGS_B, 16'h0000);
      rchk(8'h08, 16'h0000);
   endtask
   task event_flags();
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_FLAGS_A, 8'h7f);
         wr(ADDR_FLAGS_B, 8'h7f);
         pulse(8'h01 << i);
         rchk(ADDR_FLAGS_A, (i < 7) ? 16'(8'h01 << i) : 16'h0000);
         rchk(ADDR_FLAGS_B, (i < 7) ? 16'h0000 : 16'h0020);
      end
      wr(ADDR_FLAGS_A, 8'h85);
      rchk(ADDR_FLAGS_A, 16'h0005);
      wr(ADDR_FLAGS_A, 8'h04);
      rchk(ADDR_FLAGS_A, 16'h0001);
      wr(ADDR_FLAGS_B, 8'h7f);
      low_power_card_sensing <= 1'b0;
      pulse(8'h80);
      rchk(ADDR_FLAGS_B, 16'h0000);
   endtask
   task pin_request();
      wr(ADDR_FLAGS_A, 8'h7f);
      wr(ADDR_FLAGS_B, 8'h7f);
      wr(ADDR_EN_A, 8'h82);
      wr(ADDR_POWER, 8'h01);
      #1 chk(16'(o_int_req), 16'h0000);
      pulse(8'h02);
      @(posedge i_mclk);
      #1 chk(16'(o_int_req), 16'h0001);
      rchk(ADDR_FLAGS_B, 16'h0040);
      rchk(ADDR_STATUS, 16'h0001);
      rchk(ADDR_EN_A, 16'h0002);
      wr(ADDR_FLAGS_A, 8'h02);
      #1 chk(16'(o_int_req), 16'h0000);
      wr(ADDR_EN_A, 8'h02);
      wr(ADDR_FLAGS_B, 8'h7f);
   endtask
   task timer_oneshot();
      wr(ADDR_EN_B, 8'h81);
      wr(8'h12, 8'h03);
      wr(ADDR_GCTRL, 8'h11);
      rchk(ADDR_GCTRL, 16'h0001);
      wait_req();
      chk(16'(n > 15), 16'h0001);
      rchk(ADDR_FLAGS_B, 16'h0041);
      rchk(ADDR_GCTRL, 16'h0000);
      rchk(8'h14, 16'h0000);
      wr(ADDR_FLAGS_B, 8'h7f);
      #1 chk(16'(o_int_req), 16'h0000);
   endtask
   task timer_periodic();
      wr(8'h10, 8'h0c);
      rchk(ADDR_GCTRL, 16'h0001);
      repeat (2) begin
         wait_req();
         wr(ADDR_FLAGS_B, 8'h7f);
      end
      rchk(ADDR_GCTRL, 16'h0001);
      wr(ADDR_GCTRL, 8'h10);
      rchk(ADDR_GCTRL, 16'h0000);
   endtask
   task stop_watch();
      wr(8'h11, 8'hff);
      wr(8'h12, 8'h80);
      wr(8'h10, 8'h10);
      wr(ADDR_GCTRL, 8'h11);
      repeat (20) @(posedge i_mclk);
      stop_ev <= 4'h1;
      @(posedge i_mclk);
      stop_ev <= 4'h0;
      rchk(ADDR_GCTRL, 16'h0000);
      rchk(ADDR_FLAGS_B, 16'h0000);
      rchk(8'h13, 16'h00ff);
      rd(8'h14);
      n = rv;
      chk(16'(n > 8'h78 && n < 8'h80), 16'h0001);
      repeat (40) @(posedge i_mclk);
      rchk(8'h14, 16'(n));
   endtask
   // Timer 1 counts timer 0 underflows, so its count must still stand early on.
   task timer_chain();
      wr(8'h1a, 8'h01);
      wr(8'h18, 8'h0a);
      wr(8'h20, 8'h09);
      wr(8'h10, 8'h0c);
      repeat (10) @(posedge i_mclk);
      rchk(8'h1c, 16'h0001);
      repeat (600) @(posedge i_mclk);
      wr(ADDR_GCTRL, 8'h10);
      rchk(ADDR_GCTRL, 16'h0000);
      rchk(ADDR_FLAGS_B, 16'h0047);
      wr(ADDR_FLAGS_B, 8'h7f);
   endtask
   task wake_cycle();
      wr(ADDR_POWER, 8'h03);
      #1 chk(16'(o_standby), 16'h0001);
      wr(8'h30, 8'h28);
      n = 0;
      while (o_wake !== 1'b1 && n < 700) begin
         @(posedge i_mclk);
         #1 n++;
      end
      chk(16'(o_wake), 16'h0001);
      chk(16'(o_standby), 16'h0000);
      rchk(ADDR_FLAGS_B, 16'h0010);
      @(posedge i_mclk);
      cdone <= 1'b1;
      @(posedge i_mclk);
      cdone <= 1'b0;
      #1 chk(16'(o_standby), 16'h0001);
   endtask
   task give_verdict();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      i_rst = 1'b1;
      {i_wr, i_rd, i_addr, i_wdata, ev, stop_ev, cdone} = '0;
      low_power_card_sensing = 1'b1;
      repeat (8) @(posedge i_mclk);
      i_rst <= 1'b0;
      reset_values();
      event_flags();
      pin_request();
      timer_oneshot();
      timer_periodic();
      timer_chain();
      stop_watch();
      wake_cycle();
      give_verdict();
   end
   initial begin
      repeat (20000) @(posedge i_mclk);
      err_count++;
      give_verdict();
   end
endmodule
